// ===== bench/dsq_analog_model.sv
// Behavioural model of the analog integrator and comparator
`timescale 1ns/10ps
module dsq_analog_model (
   // Clock and reset
   input wire logic        clock,
   input wire logic        rst,
   // Controls from the sequencer
   input wire logic        ctrl_one,
   input wire logic        ctrl_two,
   // Input polarity and ramp-down length in cycles
   input wire logic        pos,
   input wire logic [15:0] ramp_len,
   // Comparator towards the sequencer
   output logic            comp
);
   logic [15:0] ramp_r; // Cycles in reference so far
   logic        osc_r;  // Limit-cycle toggle
   // Track the reference ramp and the auto-zero oscillation
   always_ff @(posedge clock or posedge rst)
      if (rst)
      begin
         ramp_r <= 16'h0000;
         osc_r  <= 1'b0;
      end
      else
      begin
         ramp_r <= (ctrl_one ^ ctrl_two) ? ramp_r + 16'h0001 : 16'h0000;
         osc_r  <= ~osc_r;
      end
   // Oscillates in auto-zero, flips once the integrator crosses zero
   always_comb
      if (!ctrl_one && !ctrl_two)
         comp = osc_r;
      else if (ctrl_one && ctrl_two)
         comp = pos;
      else
         comp = (ramp_r < ramp_len) ? pos : ~pos;
endmodule // dsq_analog_model

// ===== bench/dsq_sequencer_monitor.sv
// Port checker for the dual-slope sequencer
`timescale 1ns/10ps
module dsq_sequencer_monitor (
   // Clock and reset
   input wire logic       clock,
   input wire logic       rst,
   // Analog controls
   input wire logic       ctrl_one,
   input wire logic       ctrl_two,
   // Display side
   input wire logic [6:0] seg_data,
   input wire logic [4:0] digit_en,
   input wire logic       sign_neg,
   input wire logic       over_range,
   input wire logic       pulse_out
);
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   // ----------------
   // Helper counters
   // ----------------
   logic [15:0] inp_r;   // Cycles in integrate-input
   logic [15:0] pul_r;   // Cycles since pulse edge
   logic [7:0]  scn_r;   // Cycles since digit change
   logic        pul_q_r; // Delayed pulse
   logic [4:0]  dig_q_r; // Delayed digit enables
   logic [1:0]  seen_r;  // First edge seen: scan, pulse
   wire         ref_w = ctrl_one ^ ctrl_two; // Reference phase
   wire         inp_w = ctrl_one & ctrl_two; // Input phase
   // First edges after reset are skipped, their spacing is unknown
   always_ff @(posedge clock or posedge rst)
      if (rst)
      begin
         inp_r   <= 16'h0000;
         pul_r   <= 16'h0000;
         scn_r   <= 8'h00;
         pul_q_r <= 1'b0;
         dig_q_r <= 5'h00;
         seen_r  <= 2'h0;
      end
      else
      begin
         inp_r   <= inp_w ? inp_r + 16'h0001 : 16'h0000;
         pul_r   <= (pulse_out != pul_q_r) ? 16'h0000 : pul_r + 16'h0001;
         scn_r   <= (digit_en != dig_q_r) ? 8'h00 : scn_r + 8'h01;
         pul_q_r <= pulse_out;
         dig_q_r <= digit_en;
         seen_r  <= seen_r | {digit_en != dig_q_r, pulse_out != pul_q_r};
      end
   // ----------------
   // Assertions
   // ----------------
   a_input_length: assert property ($past(inp_w) && !inp_w |-> inp_r == 16'h4E20)
      else $error("integrate-input length wrong");
   a_ref_entry: assert property ($past(inp_w) && !inp_w |-> ref_w)
      else $error("reference did not follow input phase");
   a_ref_exit: assert property ($past(ref_w) && !ref_w |-> !ctrl_one && !ctrl_two)
      else $error("reference did not end in auto-zero");
   a_ref_steady: assert property ($past(ref_w) && ref_w |-> $stable(ctrl_one))
      else $error("reference controls moved");
   a_sign_latch: assert property ($past(ref_w) && !ref_w |-> ##1 sign_neg == $past(ctrl_two, 2))
      else $error("sign differs from reference polarity");
   a_over_blank: assert property (over_range && $past(over_range, 2) && |digit_en[3:0]
      |-> seg_data == 7'h00)
      else $error("over-range digit not blank");
   a_scan_period: assert property (digit_en != dig_q_r && seen_r[1] |-> scn_r == 8'hC7)
      else $error("digit scan period wrong");
   a_pulse_half: assert property (pulse_out != pul_q_r && seen_r[0] |-> pul_r == 16'h270F)
      else $error("pulse half period wrong");
endmodule // dsq_sequencer_monitor

bind dsq_sequencer dsq_sequencer_monitor u_dsq_sequencer_monitor (.clock(clock), .rst(rst),
   .ctrl_one(ctrl_one), .ctrl_two(ctrl_two), .seg_data(seg_data), .digit_en(digit_en),
   .sign_neg(sign_neg), .over_range(over_range), .pulse_out(pulse_out));

// ===== bench/dsq_sequencer_tb_top.sv
// Top-level testbench of the dual-slope sequencer
`timescale 1ns/10ps
module dsq_sequencer_tb_top;
   logic        clock, rst, comp_in, trigger_in, pos; // Stimulus
   logic        ctrl_one, ctrl_two, sign_neg, over_range; // Outputs
   logic [6:0]  seg_data, seg_s; // BCD and segment builds
   logic [4:0]  digit_en, dig_s;
   logic [16:0] result, result_s; // BCD and segment builds
   logic [15:0] ramp_len; // Cycles until the crossing
   int          failures, check_count, cyc, t_in, t_ref, exp_t, val, hold_k, lag;
   // ----------------
   // Design and partner
   // ----------------
   dsq_sequencer #(.SEVEN_SEG(1'b0)) u_dsq_sequencer (.clock(clock), .rst(rst),
      .comp_in(comp_in), .ctrl_one(ctrl_one), .ctrl_two(ctrl_two), .trigger_in(trigger_in),
      .seg_data(seg_data), .digit_en(digit_en), .sign_neg(sign_neg),
      .over_range(over_range), .pulse_out(), .result(result));
   dsq_sequencer u_dsq_sequencer_seg (.clock(clock), .rst(rst), .comp_in(comp_in),
      .ctrl_one(), .ctrl_two(), .trigger_in(trigger_in), .seg_data(seg_s), .digit_en(dig_s),
      .sign_neg(), .over_range(), .pulse_out(), .result(result_s));
   dsq_analog_model u_dsq_analog_model (.clock(clock), .rst(rst), .ctrl_one(ctrl_one),
      .ctrl_two(ctrl_two), .pos(pos), .ramp_len(ramp_len), .comp(comp_in));
   // Count a comparison, hand back its outcome
   function automatic bit pass(input logic ok);
      check_count++;
      return ok === 1'b1;
   endfunction
   // Value of four BCD digits
   function automatic int bcd(input logic [15:0] v);
      return v[15:12] * 1000 + v[11:8] * 100 + v[7:4] * 10 + v[3:0];
   endfunction
   // Segments a..g (bit 0 = a) of the decimal digits, active high
   localparam logic [6:0] SEG_TAB [10] = '{7'h3F, 7'h06, 7'h5B, 7'h4F, 7'h66,
                                           7'h6D, 7'h7D, 7'h07, 7'h7F, 7'h6F};
   task automatic miss(input string msg);
      failures++;
      $display("wrong value at %0t ns: %s", $time, msg);
   endtask
   task automatic give_verdict;
      if (failures == 0 && check_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // Clock at 25 MHz
   initial
   begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end
   // Cycle count since reset release, with a ceiling against hangs
   always @(posedge clock)
   begin
      if (!rst)
         cyc <= cyc + 1;
      if (cyc == 100000)
      begin
         miss("timeout");
         give_verdict();
      end
   end
   // ----------------
   // Main sequence
   // ----------------
   initial
   begin
      rst = 1'b1;
      trigger_in = 1'b0;
      failures = 0;
      check_count = 0;
      cyc = 0;
      void'($urandom(6374));
      pos = 1'($urandom_range(1, 0));
      ramp_len = 16'($urandom_range(6000, 1000));
      hold_k = $urandom_range(1, 0);
      lag = $urandom_range(3800, 100);
      repeat (10) @(posedge clock);
      rst <= 1'b0;
      // Trigger low holds at 20,000; raise it between two samples
      wait (cyc == 40000 + 4000 * hold_k + lag);
      @(posedge clock);
      trigger_in <= 1'b1;
      while ({ctrl_one, ctrl_two} !== 2'b11) @(negedge clock);
      t_in = cyc;
      exp_t = 60000 + 4000 * (hold_k + 1);
      if (!pass(t_in + 20 >= exp_t && t_in <= exp_t + 20)) miss("hold resume");
      while (ctrl_one & ctrl_two) @(negedge clock);
      t_ref = cyc;
      if (!pass(t_ref - t_in == 20000)) miss("input phase length");
      if (!pass({ctrl_one, ctrl_two} === {pos, ~pos})) miss("reference controls");
      while (ctrl_one ^ ctrl_two) @(negedge clock);
      val = cyc - t_ref;
      if (!pass(val >= ramp_len && val <= ramp_len + 12)) miss("crossing latency");
      if (!pass({ctrl_one, ctrl_two} === 2'b00)) miss("auto-zero controls");
      repeat (10) @(negedge clock);
      if (!pass(over_range === 1'b0 && sign_neg === ~pos)) miss("sign or range");
      val = bcd(result[15:0]);
      if (!pass(val >= ramp_len / 2 && val <= ramp_len / 2 + 6)) miss("result");
      if (!pass(result === result_s && result[16] === sign_neg)) miss("builds");
      // Multiplexed digits carry the stored BCD values
      repeat (1200)
      begin
         @(negedge clock);
         for (int i = 0; i < 4; i++)
         begin
            if (digit_en[i] && !pass(seg_data === {3'b000, result[4*i +: 4]})) miss("digit");
            if (dig_s[i] && !pass(seg_s === SEG_TAB[result[4*i +: 4]])) miss("segments");
         end
         // Half digit is zero for a reading below 10,000
         if (digit_en[4] && !pass(seg_data === 7'h00)) miss("half digit");
         if (dig_s[4] && !pass(seg_s === SEG_TAB[0])) miss("half segments");
      end
      give_verdict();
   end
endmodule // dsq_sequencer_tb_top

// ===== logic/dsq_pkg.sv
// Package: constants and state type for the dual-slope sequencer
package dsq_pkg;

   // ----------------------------------------------------------------
   // Counter landmarks (decimal counter values)
   // ----------------------------------------------------------------
   localparam logic [15:0] HOLD_COUNT    = 16'h4E20; // 20,000: hold stop point
   localparam logic [15:0] AZ_END_COUNT  = 16'h7530; // 30,000: auto-zero ends
   localparam logic [15:0] TOP_COUNT     = 16'h9C3F; // 39,999: last count
   localparam logic [15:0] OVR_COUNT     = 16'h4E20; // 20,000: over-range limit
   localparam logic [15:0] INT_STEPS     = 16'h2710; // 10,000: integrate-input length

   // ----------------------------------------------------------------
   // Oscillator divider counts
   // ----------------------------------------------------------------
   localparam logic [11:0] TRIG_SAMPLE_DIV = 12'h0FA0; // 4000 cycles per trigger sample
   localparam logic [7:0]  SCAN_DIV        = 8'h00C8;  // 200 cycles per digit
   localparam logic [14:0] PULSE_DIV       = 15'h4E20; // 20,000 cycles per pulse period
   localparam logic [14:0] PULSE_HALF      = 15'h2710; // 10,000: pulse high half

   // ----------------------------------------------------------------
   // Reset values and last digit index
   // ----------------------------------------------------------------
   localparam logic [15:0] COUNT_RESET  = 16'h0000;
   localparam logic [2:0]  DIGIT_RESET  = 3'h0;
   localparam logic [2:0]  DIGIT_LAST   = 3'h4;

   // Conversion phases
   typedef enum logic [2:0] {
      ST_AUTO_ZERO,
      ST_HOLD,
      ST_INT_INPUT,
      ST_INT_REF,
      ST_OVERFLOW_WAIT
   } dsq_phase_type;

endpackage

// ===== logic/dsq_sequencer.sv
// Dual-slope converter sequencer with multiplexed display output
`timescale 1ns/10ps

// Behaviour
// - Counter advances once per two oscillator cycles.
// - Reference end starts auto-zero, controls low.
// - Trigger high gives back-to-back conversions.
// - Trigger low in auto-zero holds at 20,000.
// - Hold samples trigger every 4000; high resumes.
// - At 30,000 controls high, integrate input.
// - Integrate input lasts exactly 10,000 counts.
// - Rollover 39,999 samples comparator, starts reference.
// - Comparator low: control one low, two high.
// - Comparator high: control one high, two low.
// - Zero crossing ends phase, latches counter.
// - No crossing by 20,000 sets over-range.
// - Over-range blanks all but top digit, sign.
// - Load 17-bit signed result in parallel.
// - Digit scan advances every 200 oscillator cycles.
// - Pulse output at oscillator over 20,000, seven-segment build only.
// - Unconnected trigger reads high, free-running.
// - Outputs seven-segment or BCD per digit.
module dsq_sequencer #(
   parameter bit SEVEN_SEG = 1'b1  // 1: seven-segment build, 0: BCD build
)(
   // Clock and reset
   input  wire logic        clock,
   input  wire logic        rst,
   // Analog processor link
   input  wire logic        comp_in,      // Comparator output, asynchronous
   output logic             ctrl_one,     // Control input one
   output logic             ctrl_two,     // Control input two
   // Trigger (pulled high externally when unconnected)
   input  wire logic        trigger_in,
   // Display
   output logic [6:0]       seg_data,     // Segments (a..g) or BCD in [3:0]
   output logic [4:0]       digit_en,     // One-hot digit enable, bit 4 = most significant
   output logic             sign_neg,     // Sign of the displayed result
   output logic             over_range,   // Over-range indication
   output logic             pulse_out,    // Oscillator divided by 20,000; held low in the BCD build
   output logic [16:0]      result       // Buffered result: sign in bit 16, four BCD digits
);

   // ----------------------------------------------------------------
   // State record
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [2:0]           comp_sync;   // Comparator synchroniser
      logic [2:0]           trig_sync;   // Trigger synchroniser
      logic                 comp_q;      // Filtered comparator level
      logic                 trig_q;      // Filtered trigger level
      logic                 half;        // Divide-by-two for the counter
      logic [15:0]          count;       // Binary image of the decimal counter
      logic [3:0][3:0]      bcd;         // Decimal digits of the counter
      logic                 bcd_top;     // Half digit of the counter
      dsq_pkg::dsq_phase_type phase;     // Conversion phase
      logic                 polarity;    // Comparator level sampled at rollover
      logic [11:0]          trig_div;    // Trigger sample divider in hold
      logic [7:0]           scan_div;    // Digit scan divider
      logic [2:0]           digit;       // Digit being shown
      logic [14:0]          pulse_div;   // Pulse output divider
      logic                 ctrl_one_r;
      logic                 ctrl_two_r;
      logic [16:0]          result_r;
      logic                 top_digit_r; // Half digit of the stored result
      logic                 over_r;
      logic [6:0]           seg_r;
      logic [4:0]           digit_en_r;
      logic                 pulse_r;
   } dsq_state_type;

   dsq_state_type st_r;   // Registered state
   dsq_state_type st_nxt; // Next state

   // ----------------------------------------------------------------
   // Seven-segment encoder (active high segments a..g)
   // ----------------------------------------------------------------
   function automatic logic [6:0] seg_of(input logic [3:0] d);
      logic [6:0] s;
      s = 7'h00;
      unique case (d)
         4'h0: s = 7'h3F;
         4'h1: s = 7'h06;
         4'h2: s = 7'h5B;
         4'h3: s = 7'h4F;
         4'h4: s = 7'h66;
         4'h5: s = 7'h6D;
         4'h6: s = 7'h7D;
         4'h7: s = 7'h07;
         4'h8: s = 7'h7F;
         4'h9: s = 7'h6F;
         default: s = 7'h00;
      endcase
      return s;
   endfunction

   // ----------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------
   always_comb
   begin
      logic       step;      // Counter advances this cycle
      logic       roll;      // Counter wraps 39,999 -> 0
      logic       crossed;   // Integrator crossed zero
      logic [3:0] shown;     // Digit value to display
      logic       blank;     // Digit is blanked
      logic       carry;
      step    = 1'b0;
      roll    = 1'b0;
      crossed = 1'b0;
      shown   = 4'h0;
      blank   = 1'b0;
      carry   = 1'b0;
      st_nxt  = st_r;

      // Three-stage synchronisers; a change counts once stages two and three agree
      st_nxt.comp_sync = {st_r.comp_sync[1:0], comp_in};
      st_nxt.trig_sync = {st_r.trig_sync[1:0], trigger_in};
      if (st_r.comp_sync[2] == st_r.comp_sync[1])
      begin
         st_nxt.comp_q = st_r.comp_sync[2];
      end
      if (st_r.trig_sync[2] == st_r.trig_sync[1])
      begin
         st_nxt.trig_q = st_r.trig_sync[2];
      end

      // Counter prescale: one step per two oscillator cycles
      st_nxt.half = ~st_r.half;
      step = st_r.half && (st_r.phase != dsq_pkg::ST_HOLD);
      roll = step && (st_r.count == dsq_pkg::TOP_COUNT);

      // Decimal counter, binary image kept alongside
      if (step)
      begin
         if (roll)
         begin
            st_nxt.count   = dsq_pkg::COUNT_RESET;
            st_nxt.bcd     = '0;
            st_nxt.bcd_top = 1'b0;
         end
         else
         begin
            st_nxt.count = st_r.count + 16'h0001;
            carry = 1'b1;
            for (int i = 0; i < 4; i++)
            begin
               if (carry)
               begin
                  if (st_r.bcd[i] == 4'h9)
                  begin
                     st_nxt.bcd[i] = 4'h0;
                  end
                  else
                  begin
                     st_nxt.bcd[i] = st_r.bcd[i] + 4'h1;
                     carry = 1'b0;
                  end
               end
            end
            // Top digit is one bit, toggled on each carry; it is the display half digit
            if (carry)
            begin
               st_nxt.bcd_top = ~st_r.bcd_top;
            end
         end
      end

      // Zero crossing: comparator leaves the level held at rollover
      crossed = (st_r.comp_q != st_r.polarity);

      // Phase sequencing
      unique case (st_r.phase)
         dsq_pkg::ST_AUTO_ZERO:
         begin
            st_nxt.ctrl_one_r = 1'b0;
            st_nxt.ctrl_two_r = 1'b0;
            if (step && (st_nxt.count == dsq_pkg::HOLD_COUNT) && !st_r.trig_q)
            begin
               // Stop the counter at 20,000 and wait for the trigger
               st_nxt.phase    = dsq_pkg::ST_HOLD;
               st_nxt.trig_div = '0;
            end
            else if (step && (st_nxt.count == dsq_pkg::AZ_END_COUNT))
            begin
               st_nxt.phase      = dsq_pkg::ST_INT_INPUT;
               st_nxt.ctrl_one_r = 1'b1;
               st_nxt.ctrl_two_r = 1'b1;
            end
         end
         dsq_pkg::ST_HOLD:
         begin
            // Trigger sampled once per 4000 oscillator pulses
            if (st_r.trig_div == dsq_pkg::TRIG_SAMPLE_DIV - 12'h001)
            begin
               st_nxt.trig_div = '0;
               if (st_r.trig_q)
               begin
                  st_nxt.phase = dsq_pkg::ST_AUTO_ZERO;
               end
            end
            else
            begin
               st_nxt.trig_div = st_r.trig_div + 12'h001;
            end
         end
         dsq_pkg::ST_INT_INPUT:
         begin
            // Runs 30,000 to 39,999 then rollover: 10,000 steps
            if (roll)
            begin
               st_nxt.phase      = dsq_pkg::ST_INT_REF;
               st_nxt.polarity   = st_r.comp_q;
               st_nxt.ctrl_one_r = st_r.comp_q;
               st_nxt.ctrl_two_r = ~st_r.comp_q;
            end
         end
         dsq_pkg::ST_INT_REF:
         begin
            if (crossed)
            begin
               // Store sign, half digit and four digits in one load
               st_nxt.result_r    = {~st_r.polarity, st_r.bcd};
               st_nxt.top_digit_r = st_r.bcd_top;
               st_nxt.over_r     = 1'b0;
               st_nxt.phase      = dsq_pkg::ST_OVERFLOW_WAIT;
            end
            else if (step && (st_nxt.count == dsq_pkg::OVR_COUNT))
            begin
               st_nxt.result_r    = {~st_r.polarity, 16'h0000};
               st_nxt.top_digit_r = 1'b1;
               st_nxt.over_r     = 1'b1;
               st_nxt.phase      = dsq_pkg::ST_OVERFLOW_WAIT;
            end
         end
         dsq_pkg::ST_OVERFLOW_WAIT:
         begin
            // Controls low: analog side is back in auto-zero
            st_nxt.ctrl_one_r = 1'b0;
            st_nxt.ctrl_two_r = 1'b0;
            st_nxt.phase      = dsq_pkg::ST_AUTO_ZERO;
         end
         default:
         begin
            st_nxt.phase = dsq_pkg::ST_AUTO_ZERO;
         end
      endcase

      // Digit scan, one digit per 200 oscillator cycles
      if (st_r.scan_div == dsq_pkg::SCAN_DIV - 8'h01)
      begin
         st_nxt.scan_div = '0;
         st_nxt.digit    = (st_r.digit == dsq_pkg::DIGIT_LAST) ? dsq_pkg::DIGIT_RESET
                                                              : st_r.digit + 3'h1;
      end
      else
      begin
         st_nxt.scan_div = st_r.scan_div + 8'h01;
      end

      // Output for the digit now selected
      if (st_r.digit == dsq_pkg::DIGIT_LAST)
      begin
         // Half digit; the sign has an output of its own
         shown = {3'h0, st_r.top_digit_r};
      end
      else
      begin
         shown = st_r.result_r[st_r.digit*4 +: 4];
         blank = st_r.over_r;
      end
      if (blank)
      begin
         st_nxt.seg_r = 7'h00;
      end
      else if (SEVEN_SEG)
      begin
         st_nxt.seg_r = seg_of(shown);
      end
      else
      begin
         st_nxt.seg_r = {3'h0, shown};
      end
      st_nxt.digit_en_r = 5'h01 << st_r.digit;

      // Pulse output: oscillator divided by 20,000, held low in the BCD build
      if (st_r.pulse_div == dsq_pkg::PULSE_DIV - 15'h0001)
      begin
         st_nxt.pulse_div = '0;
      end
      else
      begin
         st_nxt.pulse_div = st_r.pulse_div + 15'h0001;
      end
      st_nxt.pulse_r = SEVEN_SEG && (st_r.pulse_div < dsq_pkg::PULSE_HALF);
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         st_r           <= '0;
         st_r.comp_sync <= 3'h0;
         st_r.trig_sync <= 3'h7;
         st_r.trig_q    <= 1'b1;
         st_r.phase     <= dsq_pkg::ST_AUTO_ZERO;
         st_r.digit     <= dsq_pkg::DIGIT_RESET;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   // Outputs straight from the state register
   assign ctrl_one   = st_r.ctrl_one_r;
   assign ctrl_two   = st_r.ctrl_two_r;
   assign seg_data   = st_r.seg_r;
   assign digit_en   = st_r.digit_en_r;
   assign sign_neg   = st_r.result_r[16];
   assign over_range = st_r.over_r;
   assign pulse_out  = st_r.pulse_r;
   assign result     = st_r.result_r;

endmodule // dsq_sequencer
